// ==== rtl/ccr_config_regs.sv ====
`timescale 1ns/1ps
`include "ccr_defs.svh"

// Notes on behaviour
// [R1] Only listed addresses and bits work; others read zero, except port configuration bits 4 and 3, which read one; writes ignored.
// [R2] Bit order at bits 6 and 1, soft reset at 5 and 2, mirrored.
// [R3] Port configuration resets to 0x18.
// [R4] Address 0x01 returns a fixed part identifier; writes ignored.
// [R5] Address 0x02 returns speed grade code in bits 6 to 4.
// [R6] Shadow writes 0x08..0x18 apply when 0x01 written to 0xFF; bit self-clears.
// [R7] Shift order MSB first by default; bit-order select gives LSB first.
// [R8] Any device reset reloads the registers with their defaults.
// [R9] Soft reset bits clear themselves when the reset sequence ends.
module ccr_config_regs #(
   parameter logic [7:0] PART_ID     = 8'h5a, // Arbitrary value
   parameter logic [2:0] SPEED_GRADE = 3'h5,  // Arbitrary value
   parameter int unsigned SOFT_RST_CYCLES = `CCR_SOFT_RST_CYC
) (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_rdata,
   output logic            o_rvalid,
   output logic            o_lsb_first,
   output logic            o_soft_reset,
   output logic            o_commit,
   output logic            o_shadow_wr
);

   // Port configuration
   logic [7:0] cfg_ff;
   logic [7:0] nxt_cfg;
   logic       lsb_ff;
   logic       nxt_lsb;
   logic       want_lsb;
   logic       want_srst;

   // Shadow transfer
   logic [7:0] commit_ff;
   logic [7:0] nxt_commit;
   logic       commit_p_ff;
   logic       nxt_commit_p;
   logic       shw_ff;
   logic       nxt_shw;

   // Read answer
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic       rvalid_ff;
   logic       nxt_rvalid;
   logic [7:0] grade_word;

   // Software reset
   logic       srst_ff;
   logic       nxt_srst;
   logic       rst_start;
   logic       rst_active;
   logic       rst_done;

   // Write decode
   logic       wr_ok;
   logic       wr_cfg;
   logic       wr_commit;
   logic       wr_shadow;
   logic       in_shadow;

   // Writes are refused while the soft reset runs and in its done cycle
   assign wr_ok     = i_wr && !rst_active && !rst_done;
   assign in_shadow = (i_addr >= `CCR_ADDR_SHADOW_LO) && (i_addr <= `CCR_ADDR_SHADOW_HI);

   // Either nibble sets a field, so both shift orders decode alike
   assign want_lsb  = i_wdata[`CCR_CFG_LSB_FIRST_HI] || i_wdata[`CCR_CFG_LSB_FIRST_LO]; // [R2]
   assign want_srst = i_wdata[`CCR_CFG_SOFT_RST_HI] || i_wdata[`CCR_CFG_SOFT_RST_LO];   // [R2]
   assign rst_start = wr_cfg && want_srst;

   // Address decode
   always_comb begin
      wr_cfg    = 1'b0;
      wr_commit = 1'b0;
      wr_shadow = 1'b0;
      if (wr_ok) begin
         if (i_addr == `CCR_ADDR_PORT_CFG) begin
            wr_cfg = 1'b1;
         end else if (i_addr == `CCR_ADDR_COMMIT) begin
            wr_commit = (i_wdata == `CCR_COMMIT_VALUE); // [R6]
         end else if (in_shadow) begin
            wr_shadow = 1'b1; // [R6]
         end
      end
   end

   // Speed grade code in its field, open bits zero
   always_comb begin
      grade_word                                = 8'h00;
      grade_word[`CCR_GRADE_MSB:`CCR_GRADE_LSB] = SPEED_GRADE; // [R5]
   end

   // Counts the software reset sequence
   ccr_soft_reset #(
      .CYCLES (SOFT_RST_CYCLES)
   ) u_soft_reset (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_start  (rst_start),
      .o_active (rst_active),
      .o_done   (rst_done)
   );

   // Port configuration group
   always_comb begin
      nxt_cfg = cfg_ff;
      if (rst_done) begin
         nxt_cfg = `CCR_CFG_RESET; // [R9] [R8]
      end else if (wr_cfg) begin
         // Open bits keep their fixed pattern
         nxt_cfg = `CCR_CFG_RESET; // [R2] [R1]
         if (want_lsb) begin
            nxt_cfg[`CCR_CFG_LSB_FIRST_HI] = 1'b1; // [R2]
            nxt_cfg[`CCR_CFG_LSB_FIRST_LO] = 1'b1; // [R2]
         end
         if (want_srst) begin
            nxt_cfg[`CCR_CFG_SOFT_RST_HI] = 1'b1; // [R2]
            nxt_cfg[`CCR_CFG_SOFT_RST_LO] = 1'b1; // [R2]
         end
      end
      nxt_lsb = nxt_cfg[`CCR_CFG_LSB_FIRST_LO]; // [R7]
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_ff <= `CCR_CFG_RESET; // [R3] [R8]
         lsb_ff <= 1'b0; // [R7]
      end else begin
         cfg_ff <= nxt_cfg;
         lsb_ff <= nxt_lsb;
      end
   end

   // Shadow transfer group: the commit bit self-clears one cycle after it is set
   always_comb begin
      nxt_commit   = commit_ff;
      nxt_commit_p = 1'b0;
      if (rst_done) begin
         nxt_commit = `CCR_COMMIT_RESET; // [R8]
      end else if (commit_ff[`CCR_COMMIT_BIT]) begin
         nxt_commit   = `CCR_COMMIT_RESET; // [R6]
         nxt_commit_p = 1'b1; // [R6]
      end
      if (wr_commit) begin
         nxt_commit = `CCR_COMMIT_VALUE; // [R6]
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         commit_ff   <= `CCR_COMMIT_RESET; // [R8]
         commit_p_ff <= 1'b0;
      end else begin
         commit_ff   <= nxt_commit;
         commit_p_ff <= nxt_commit_p;
      end
   end

   // Shadow write strobe group
   always_comb begin
      nxt_shw = wr_shadow; // [R6]
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         shw_ff <= 1'b0;
      end else begin
         shw_ff <= nxt_shw;
      end
   end

   // Software reset status group
   always_comb begin
      nxt_srst = rst_start || rst_active;
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         srst_ff <= 1'b0;
      end else begin
         srst_ff <= nxt_srst;
      end
   end

   // Read path: unmapped addresses and open bits return zero, except port configuration bits 4 and 3, which read one
   always_comb begin
      nxt_rdata  = 8'h00;
      nxt_rvalid = i_rd;
      if (i_rd) begin
         if (i_addr == `CCR_ADDR_PORT_CFG) begin
            nxt_rdata = cfg_ff;
         end else if (i_addr == `CCR_ADDR_PART_ID) begin
            nxt_rdata = PART_ID; // [R4]
         end else if (i_addr == `CCR_ADDR_SPEED_GRADE) begin
            nxt_rdata = grade_word; // [R5]
         end else if (i_addr == `CCR_ADDR_COMMIT) begin
            nxt_rdata = commit_ff;
         end else begin
            nxt_rdata = 8'h00; // [R1]
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         rdata_ff  <= 8'h00;
         rvalid_ff <= 1'b0;
      end else begin
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // Every output comes straight from a flip-flop
   assign o_rdata      = rdata_ff;
   assign o_rvalid     = rvalid_ff;
   assign o_lsb_first  = lsb_ff;
   assign o_soft_reset = srst_ff;
   assign o_commit     = commit_p_ff;
   assign o_shadow_wr  = shw_ff;

endmodule : ccr_config_regs

// ==== rtl/ccr_defs.svh ====
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// Register addresses
`define CCR_ADDR_PORT_CFG      8'h00
`define CCR_ADDR_PART_ID       8'h01
`define CCR_ADDR_SPEED_GRADE   8'h02
`define CCR_ADDR_SHADOW_LO     8'h08
`define CCR_ADDR_SHADOW_HI     8'h18
`define CCR_ADDR_COMMIT        8'hff

// Port configuration fields
`define CCR_CFG_LSB_FIRST_HI   6
`define CCR_CFG_SOFT_RST_HI    5
`define CCR_CFG_SOFT_RST_LO    2
`define CCR_CFG_LSB_FIRST_LO   1
`define CCR_CFG_RESET          8'h18
`define CCR_CFG_WMASK          8'h66

// Speed grade field
`define CCR_GRADE_LSB          4
`define CCR_GRADE_MSB          6

// Commit register
`define CCR_COMMIT_BIT         0
`define CCR_COMMIT_VALUE       8'h01
`define CCR_COMMIT_RESET       8'h00

// Software reset duration
`define CCR_SOFT_RST_NS        400
`define CCR_CLK_PERIOD_NS      100
`define CCR_SOFT_RST_CYC       ((`CCR_SOFT_RST_NS + `CCR_CLK_PERIOD_NS - 1) / `CCR_CLK_PERIOD_NS)

`endif

// ==== rtl/ccr_pkg.sv ====
package ccr_pkg;

   typedef enum logic [1:0] {
      CCR_ST_RUN   = 2'b00,
      CCR_ST_RESET = 2'b01,
      CCR_ST_DONE  = 2'b10
   } ccr_rst_state_t;

endpackage : ccr_pkg

// ==== rtl/ccr_soft_reset.sv ====
`timescale 1ns/1ps
`include "ccr_defs.svh"

module ccr_soft_reset #(
   parameter int unsigned CYCLES = `CCR_SOFT_RST_CYC
) (
   input  wire logic i_clk,
   input  wire logic i_nrst,
   input  wire logic i_start,
   output logic      o_active,
   output logic      o_done
);

   ccr_pkg::ccr_rst_state_t state_ff;
   ccr_pkg::ccr_rst_state_t nxt_state;
   logic [15:0]             cnt_ff;
   logic [15:0]             nxt_cnt;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      case (state_ff)
         ccr_pkg::CCR_ST_RUN: begin
            if (i_start) begin
               nxt_state = ccr_pkg::CCR_ST_RESET;
               nxt_cnt   = 16'h0000;
            end
         end
         ccr_pkg::CCR_ST_RESET: begin
            nxt_cnt = cnt_ff + 16'h0001;
            if (cnt_ff == 16'(CYCLES - 1)) begin
               nxt_state = ccr_pkg::CCR_ST_DONE;
            end
         end
         ccr_pkg::CCR_ST_DONE: begin
            nxt_state = ccr_pkg::CCR_ST_RUN;
         end
         default: begin
            nxt_state = ccr_pkg::CCR_ST_RUN;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= ccr_pkg::CCR_ST_RUN;
         cnt_ff   <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   assign o_active = (state_ff == ccr_pkg::CCR_ST_RESET);
   assign o_done   = (state_ff == ccr_pkg::CCR_ST_DONE);

endmodule : ccr_soft_reset

// ==== testbench/ccr_config_regs_assertions.sv ====
`timescale 1ns/1ps
module ccr_config_regs_chk (
   input wire logic       i_clk,
   input wire logic       i_nrst,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic [7:0] o_rdata,
   input wire logic       o_rvalid,
   input wire logic       o_lsb_first,
   input wire logic       o_soft_reset,
   input wire logic       o_commit,
   input wire logic       o_shadow_wr
);
   logic sr_ff;
   logic wok;
   // Writes are ignored during soft reset and its done cycle
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sr_ff <= 1'b0;
      end else begin
         sr_ff <= o_soft_reset;
      end
   end
   assign wok = i_wr && !o_soft_reset && !sr_ff;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   chk_read_answer: assert property (i_rd |=> o_rvalid) else $error("no rvalid");
   chk_idle_rdata: assert property (!o_rvalid |-> o_rdata == 8'h00) else $error("rdata");
   chk_unmapped_read: assert property (i_rd && i_addr == 8'h05 |=> o_rdata == 8'h00) else $error("unmapped");
   chk_grade_open: assert property (i_rd && i_addr == 8'h02 |=> {o_rdata[7], o_rdata[3:0]} == 5'h00)
      else $error("grade");
   chk_commit_pulse: assert property (wok && i_addr == 8'hff && i_wdata == 8'h01 |=> ##1 o_commit
      ##1 (!o_commit || $past(wok && i_addr == 8'hff && i_wdata == 8'h01, 2))) else $error("commit");
   chk_shadow_pulse: assert property (wok && i_addr inside {[8'h08:8'h18]} |=> o_shadow_wr
      ##1 (!o_shadow_wr || $past(wok && i_addr inside {[8'h08:8'h18]}))) else $error("shadow");
   chk_order_select: assert property (wok && i_addr == 8'h00 && !i_wdata[5] && !i_wdata[2]
      |=> o_lsb_first == $past(i_wdata[6] | i_wdata[1])) else $error("lsb");
   chk_soft_reset_seq: assert property (wok && i_addr == 8'h00 && (i_wdata[5] || i_wdata[2])
      |=> o_soft_reset [*4] ##[1:2] !o_soft_reset && !o_lsb_first) else $error("soft reset");
endmodule : ccr_config_regs_chk
bind ccr_config_regs ccr_config_regs_chk i_chk (.*);

// ==== testbench/ccr_host_model.sv ====
`timescale 1ns/1ps
module ccr_host_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end
   // One byte access; released address and data lines show the inverse of the last value
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk);
      #1;
      o_wr = w;
      o_rd = !w;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
      q = i_rdata;
   endtask : xfer
endmodule : ccr_host_model

// ==== testbench/converter_chip_config_registers_test.sv ====
`timescale 1ns/1ps
module converter_chip_config_registers_test;
   logic       i_clk = 1'b0;
   logic       i_nrst = 1'b0;
   logic       wr, rd, rv, lsb, srst, cmt, shw;
   logic [7:0] addr, wdata, rdata, r;
   int         n_errors = 0;
   int         tests_run = 0;
   int         n_cmt = 0;
   int         n_shw = 0;
   always #50 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      n_cmt += int'(cmt === 1'b1);
      n_shw += int'(shw === 1'b1);
   end
   ccr_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
   ccr_config_regs #(.PART_ID(8'h5a), .SPEED_GRADE(3'h5)) i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wr(wr),
      .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
      .o_rdata(rdata), .o_rvalid(rv), .o_lsb_first(lsb), .o_soft_reset(srst), .o_commit(cmt), .o_shadow_wr(shw));
   task automatic chk(input logic [7:0] got, input logic [7:0] e);
      tests_run++;
      if (got !== e) begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, e);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      i_host.xfer(1'b1, a, d, r);
   endtask : wr_reg
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      i_host.xfer(1'b0, a, 8'h00, r);
      chk(r, e);
      chk({7'h00, rv}, 8'h01);
   endtask : rchk
   task automatic stop_test();
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (20) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      rchk(8'h00, 8'h18);
      rchk(8'h01, 8'h5a);
      rchk(8'h02, 8'h50);
      rchk(8'hff, 8'h00);
      rchk(8'h05, 8'h00);
      wr_reg(8'h01, 8'ha5);
      wr_reg(8'h02, 8'hff);
      rchk(8'h01, 8'h5a);
      rchk(8'h02, 8'h50);
      wr_reg(8'h00, 8'h42);
      chk({7'h00, lsb}, 8'h01);
      rchk(8'h00, 8'h5a);
      wr_reg(8'h00, 8'h18);
      chk({7'h00, lsb}, 8'h00);
      wr_reg(8'h00, 8'h02);
      rchk(8'h00, 8'h5a);
      wr_reg(8'hff, 8'h01);
      wr_reg(8'hff, 8'h03);
      rchk(8'hff, 8'h00);
      chk(8'(n_cmt), 8'h01);
      wr_reg(8'h07, 8'h5c);
      wr_reg(8'h08, 8'h5c);
      wr_reg(8'h18, 8'h5c);
      wr_reg(8'h19, 8'h5c);
      rchk(8'h19, 8'h00);
      chk(8'(n_shw), 8'h02);
      wr_reg(8'h00, 8'h66);
      chk({7'h00, srst}, 8'h01);
      wr_reg(8'h00, 8'h42);
      repeat (8) @(posedge i_clk);
      rchk(8'h00, 8'h18);
      chk({7'h00, lsb}, 8'h00);
      wr_reg(8'h00, 8'h42);
      @(posedge i_clk);
      #1;
      i_nrst = 1'b0;
      repeat (2) @(posedge i_clk);
      #1;
      i_nrst = 1'b1;
      chk({7'h00, lsb}, 8'h00);
      rchk(8'h00, 8'h18);
      stop_test();
   end
   initial begin
      #400000;
      n_errors++;
      stop_test();
   end
endmodule : converter_chip_config_registers_test
